// ---- ppi_pkg.sv ----
// Constants and types for the port pin interrupt block
package ppi_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int unsigned PPI_PINS   = 8;
  localparam int unsigned PPI_ADDR_W = 8;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] PPI_OFF_PIN_SEL  = 8'h00;
  localparam logic [7:0] PPI_OFF_EDGE_SEL = 8'h04;
  localparam logic [7:0] PPI_OFF_CTRL     = 8'h08;
  localparam logic [7:0] PPI_OFF_STATUS   = 8'h0c;
  localparam logic [7:0] PPI_OFF_MASK     = 8'h10;
  localparam logic [7:0] PPI_OFF_PIN_LVL  = 8'h14;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] PPI_RST_PIN_SEL  = 8'h00;
  localparam logic [7:0] PPI_RST_EDGE_SEL = 8'h00;
  localparam logic [7:0] PPI_RST_PULL_EN  = 8'h00;
  localparam logic       PPI_RST_LVL_MODE = 1'h0;
  localparam logic       PPI_RST_MASK     = 1'h0;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned PPI_CTRL_LVL_BIT  = 0;
  localparam int unsigned PPI_CTRL_PULL_LSB = 8;
  localparam int unsigned PPI_STAT_BIT      = 0;
  localparam int unsigned PPI_LANE_LO       = 0;
  localparam int unsigned PPI_LANE_HI       = 1;

  // ----------------------------------------
  // Bus responses
  // ----------------------------------------
  localparam logic [1:0] PPI_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PPI_RESP_SLVERR = 2'h2;

endpackage

// ---- ppi_pull.sv ----
// Pull device direction per pin
`timescale 1ns/1ps
module ppi_pull
  import ppi_pkg::*;
#(
  parameter int unsigned PINS = PPI_PINS
) (
  // Settings
  input  wire logic [PINS-1:0] pull_en,
  input  wire logic [PINS-1:0] edge_sel,
  // Pull enables
  output logic      [PINS-1:0] pull_up,
  output logic      [PINS-1:0] pull_dn
);

  // ----------------------------------------
  // Direction select
  // ----------------------------------------
  always_comb begin
    pull_up = pull_en & ~edge_sel;
    pull_dn = pull_en & edge_sel;
  end

endmodule

// ---- ppi_detect.sv ----
// Per-pin active condition and trigger detection
`timescale 1ns/1ps
module ppi_detect
  import ppi_pkg::*;
#(
  parameter int unsigned PINS = PPI_PINS
) (
  // Clock and reset
  input  wire logic            clock,
  input  wire logic            sys_rst,
  // Pins and settings
  input  wire logic [PINS-1:0] pin_in,
  input  wire logic [PINS-1:0] pin_sel,
  input  wire logic [PINS-1:0] edge_sel,
  input  wire logic            lvl_mode,
  // Trigger per pin
  output logic      [PINS-1:0] trig
);

  typedef struct packed {
    logic [PINS-1:0] act_prev;
  } ppi_det_state_t;

  ppi_det_state_t q;
  ppi_det_state_t d;
  logic [PINS-1:0] act;

  // ----------------------------------------
  // Detection
  // ----------------------------------------
  always_comb begin
    act = ~(pin_in ^ edge_sel);
    d = q;
    d.act_prev = act;
    if (lvl_mode) begin
      trig = pin_sel & act;
    end else begin
      trig = pin_sel & act & ~q.act_prev;
    end
  end

  // Previous state starts active so reset gives no false edge
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{act_prev: '1};
    end else begin
      q <= d;
    end
  end

endmodule

// ---- ppi_port_irq.sv ----
// Port pin interrupt configuration block with AXI4-Lite registers
// Function
// - Each pin-select bit enables its pin as interrupt source; cleared bit excludes it.
// - Edge-select 0: pull-up, falling edge or low level is active.
// - Edge-select 1: pull-down, rising edge or high level is active.
// - One edge-select bit sets polarity and pull; pull only when enabled.
`timescale 1ns/1ps
module ppi_port_irq
  import ppi_pkg::*;
#(
  parameter int unsigned PINS = PPI_PINS
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  sys_rst,
  // AXI4-Lite write address
  input  wire logic [PPI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response
  output logic      [1:0]            s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [PPI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data
  output logic      [31:0]           s_axi_rdata,
  output logic      [1:0]            s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Port pins
  input  wire logic [PINS-1:0]       port_pin_in,
  output logic      [PINS-1:0]       port_pull_up_en,
  output logic      [PINS-1:0]       port_pull_down_en,
  // Interrupt
  output logic                       irq
);

  typedef struct packed {
    logic [PINS-1:0]       pin_sel;
    logic [PINS-1:0]       edge_sel;
    logic [PINS-1:0]       pull_en;
    logic                  lvl_mode;
    logic                  status;
    logic                  mask;
    logic [PINS-1:0]       pull_up;
    logic [PINS-1:0]       pull_dn;
    logic                  irq;
    logic                  aw_hold;
    logic [PPI_ADDR_W-1:0] aw_addr;
    logic                  awready;
    logic                  w_hold;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } ppi_state_t;

  ppi_state_t      q;
  ppi_state_t      d;
  logic [PINS-1:0] trig;
  logic [PINS-1:0] pu_c;
  logic [PINS-1:0] pd_c;
  logic            event_c;
  logic            clr_c;
  logic            wr_fire;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic logic ppi_hit(input logic [PPI_ADDR_W-1:0] a);
    ppi_hit = (a == PPI_OFF_PIN_SEL) || (a == PPI_OFF_EDGE_SEL) ||
              (a == PPI_OFF_CTRL) || (a == PPI_OFF_STATUS) ||
              (a == PPI_OFF_MASK) || (a == PPI_OFF_PIN_LVL);
  endfunction

  function automatic logic [7:0] ppi_lane(input logic [7:0] old, input logic [31:0] data,
                                          input logic [3:0] strb, input int unsigned lane);
    ppi_lane = strb[lane] ? data[lane*8 +: 8] : old;
  endfunction

  // ----------------------------------------
  // Submodules
  // ----------------------------------------
  ppi_detect #(
    .PINS     (PINS)
  ) u_detect (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .pin_in   (port_pin_in),
    .pin_sel  (q.pin_sel),
    .edge_sel (q.edge_sel),
    .lvl_mode (q.lvl_mode),
    .trig     (trig)
  );

  ppi_pull #(
    .PINS     (PINS)
  ) u_pull (
    .pull_en  (q.pull_en),
    .edge_sel (q.edge_sel),
    .pull_up  (pu_c),
    .pull_dn  (pd_c)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    d = q;
    event_c = |trig;
    clr_c = 1'b0;
    wr_fire = 1'b0;
    // Write channels, taken in either order
    if (s_axi_awvalid && q.awready) begin
      d.aw_hold = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && q.wready) begin
      d.w_hold = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (d.aw_hold && d.w_hold && !d.bvalid) begin
      wr_fire = 1'b1;
      d.aw_hold = 1'b0;
      d.w_hold = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = ppi_hit(d.aw_addr) ? PPI_RESP_OKAY : PPI_RESP_SLVERR;
      case (d.aw_addr)
        PPI_OFF_PIN_SEL: begin
          d.pin_sel = ppi_lane(q.pin_sel, d.w_data, d.w_strb, PPI_LANE_LO);
        end
        PPI_OFF_EDGE_SEL: begin
          d.edge_sel = ppi_lane(q.edge_sel, d.w_data, d.w_strb, PPI_LANE_LO);
        end
        PPI_OFF_CTRL: begin
          if (d.w_strb[PPI_LANE_LO]) begin
            d.lvl_mode = d.w_data[PPI_CTRL_LVL_BIT];
          end
          d.pull_en = ppi_lane(q.pull_en, d.w_data, d.w_strb, PPI_LANE_HI);
        end
        PPI_OFF_STATUS: begin
          clr_c = d.w_strb[PPI_LANE_LO] && d.w_data[PPI_STAT_BIT];
        end
        PPI_OFF_MASK: begin
          if (d.w_strb[PPI_LANE_LO]) begin
            d.mask = d.w_data[PPI_STAT_BIT];
          end
        end
        default: begin
          d.bresp = ppi_hit(d.aw_addr) ? PPI_RESP_OKAY : PPI_RESP_SLVERR;
        end
      endcase
    end
    d.awready = !d.aw_hold;
    d.wready = !d.w_hold;
    // Read channel
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && q.arready) begin
      d.rvalid = 1'b1;
      d.rresp = ppi_hit(s_axi_araddr) ? PPI_RESP_OKAY : PPI_RESP_SLVERR;
      d.rdata = '0;
      case (s_axi_araddr)
        PPI_OFF_PIN_SEL: begin
          d.rdata[PINS-1:0] = q.pin_sel;
        end
        PPI_OFF_EDGE_SEL: begin
          d.rdata[PINS-1:0] = q.edge_sel;
        end
        PPI_OFF_CTRL: begin
          d.rdata[PPI_CTRL_LVL_BIT] = q.lvl_mode;
          d.rdata[PPI_CTRL_PULL_LSB +: PINS] = q.pull_en;
        end
        PPI_OFF_STATUS: begin
          d.rdata[PPI_STAT_BIT] = q.status;
        end
        PPI_OFF_MASK: begin
          d.rdata[PPI_STAT_BIT] = q.mask;
        end
        PPI_OFF_PIN_LVL: begin
          d.rdata[PINS-1:0] = port_pin_in;
        end
        default: begin
          d.rdata = '0;
        end
      endcase
    end
    d.arready = !d.rvalid;
    // Latched request, set wins over clear
    d.status = (q.status && !clr_c) || event_c;
    d.irq = d.status && d.mask;
    d.pull_up = pu_c;
    d.pull_dn = pd_c;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '{pin_sel: PPI_RST_PIN_SEL, edge_sel: PPI_RST_EDGE_SEL, pull_en: PPI_RST_PULL_EN,
             lvl_mode: PPI_RST_LVL_MODE, mask: PPI_RST_MASK, bresp: PPI_RESP_OKAY,
             rresp: PPI_RESP_OKAY, default: '0};
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign s_axi_awready     = q.awready;
  assign s_axi_wready      = q.wready;
  assign s_axi_bvalid      = q.bvalid;
  assign s_axi_bresp       = q.bresp;
  assign s_axi_arready     = q.arready;
  assign s_axi_rvalid      = q.rvalid;
  assign s_axi_rdata       = q.rdata;
  assign s_axi_rresp       = q.rresp;
  assign port_pull_up_en   = q.pull_up;
  assign port_pull_down_en = q.pull_dn;
  assign irq               = q.irq;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_unselected_quiet;
    @(posedge clock) disable iff (sys_rst)
    (trig & ~q.pin_sel) == '0;
  endproperty
  a_unselected_quiet: assert property (p_unselected_quiet) else $error("trigger on unselected pin");

  property p_falling_sets;
    @(posedge clock) disable iff (sys_rst)
    (!q.lvl_mode && $stable(q.edge_sel) && |(q.pin_sel & ~q.edge_sel & $past(port_pin_in) & ~port_pin_in))
    |=> q.status;
  endproperty
  a_falling_sets: assert property (p_falling_sets) else $error("falling edge not latched");

  property p_rising_sets;
    @(posedge clock) disable iff (sys_rst)
    (!q.lvl_mode && $stable(q.edge_sel) && |(q.pin_sel & q.edge_sel & ~$past(port_pin_in) & port_pin_in))
    |=> q.status;
  endproperty
  a_rising_sets: assert property (p_rising_sets) else $error("rising edge not latched");

  property p_pull_dir;
    @(posedge clock) disable iff (sys_rst)
    ##1 (port_pull_up_en == ($past(q.pull_en) & ~$past(q.edge_sel))) &&
        (port_pull_down_en == ($past(q.pull_en) & $past(q.edge_sel)));
  endproperty
  a_pull_dir: assert property (p_pull_dir) else $error("pull direction wrong");

  property p_pull_gated;
    @(posedge clock) disable iff (sys_rst)
    ((port_pull_up_en & port_pull_down_en) == '0) && (((port_pull_up_en | port_pull_down_en) & ~$past(q.pull_en)) == '0);
  endproperty
  a_pull_gated: assert property (p_pull_gated) else $error("pull active while disabled");

  property p_req_held;
    @(posedge clock) disable iff (sys_rst)
    (q.status && !clr_c) |=> q.status;
  endproperty
  a_req_held: assert property (p_req_held) else $error("request dropped without acknowledge");

  property p_irq_follows;
    @(posedge clock) disable iff (sys_rst)
    (q.status && !clr_c) |=> (irq == q.mask);
  endproperty
  a_irq_follows: assert property (p_irq_follows) else $error("interrupt output not raised");

  property p_bvalid_hold;
    @(posedge clock) disable iff (sys_rst)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp));
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

  property p_write_answer;
    @(posedge clock) disable iff (sys_rst)
    wr_fire |=> s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered");

endmodule

// ---- ppi_pin_model.sv ----
// Off-chip drivers on the port pins, with pull resolution
`timescale 1ns/1ps
module ppi_pin_model (
  // Clock
  input  wire logic       clock,
  // Off-chip drivers
  input  wire logic [7:0] drv_en,
  input  wire logic [7:0] drv_val,
  // Pull devices from the block
  input  wire logic [7:0] pull_up,
  input  wire logic [7:0] pull_dn,
  // Resolved pin levels
  output logic      [7:0] pin
);
  logic [7:0] float_q;

  // Undriven pin without pull keeps changing
  always_ff @(posedge clock) begin
    float_q <= ~pin;
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (drv_en[i]) begin
        pin[i] = drv_val[i];
      end else if (pull_up[i]) begin
        pin[i] = 1'b1;
      end else if (pull_dn[i]) begin
        pin[i] = 1'b0;
      end else begin
        pin[i] = float_q[i];
      end
    end
  end
endmodule

// ---- ppi_port_irq_tb_top.sv ----
// Testbench for the port pin interrupt block
`timescale 1ns/1ps
module ppi_port_irq_tb_top
  import ppi_pkg::*;
;
  logic                  clock;
  logic                  sys_rst;
  logic [PPI_ADDR_W-1:0] awaddr;
  logic [PPI_ADDR_W-1:0] araddr;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready, irq;
  logic [31:0]           wdata, rdata;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp;
  logic [7:0]            pin, pull_up, pull_dn, drv_en, drv_val;
  int                    errors, check_count;

  ppi_port_irq u_dut (
    .clock(clock), .sys_rst(sys_rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_pin_in(pin), .port_pull_up_en(pull_up), .port_pull_down_en(pull_dn), .irq(irq)
  );

  ppi_pin_model u_pins (
    .clock(clock), .drv_en(drv_en), .drv_val(drv_val),
    .pull_up(pull_up), .pull_dn(pull_dn), .pin(pin)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic conclude;
    if (errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    // Response kept waiting one cycle before it is taken
    bready <= 1'b1;
    do begin
      @(posedge clock);
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({29'h0, bvalid, bresp}, {29'h0, 1'b1, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk({29'h0, rvalid, rresp}, {29'h0, 1'b1, er});
    chk(rdata, exp);
  endtask

  task automatic pins(input logic [7:0] en, input logic [7:0] val);
    @(posedge clock);
    drv_en <= en;
    drv_val <= val;
    repeat (3) @(posedge clock);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  initial begin
    #(40 * 5000);
    errors++;
    conclude();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    logic [7:0] offs [5];
    offs = '{PPI_OFF_PIN_SEL, PPI_OFF_EDGE_SEL, PPI_OFF_CTRL, PPI_OFF_STATUS, PPI_OFF_MASK};
    errors = 0;
    check_count = 0;
    sys_rst = 1'b1;
    {awaddr, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wdata = 32'h0;
    wstrb = 4'hf;
    drv_en = 8'hff;
    drv_val = 8'hff;
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    foreach (offs[i]) rd(offs[i], 32'h0, PPI_RESP_OKAY);
    rd(8'h18, 32'h0, PPI_RESP_SLVERR);
    rd(8'h01, 32'h0, PPI_RESP_SLVERR);
    wr(8'h05, 32'h000000ff, PPI_RESP_SLVERR);
    rd(PPI_OFF_EDGE_SEL, 32'h0, PPI_RESP_OKAY);
    // Pull direction and pull enable
    wr(PPI_OFF_EDGE_SEL, 32'h0000000f, PPI_RESP_OKAY);
    wr(PPI_OFF_CTRL, 32'h00003c00, PPI_RESP_OKAY);
    cyc(2);
    chk({24'h0, pull_up}, 32'h30);
    chk({24'h0, pull_dn}, 32'h0c);
    wr(PPI_OFF_CTRL, 32'h0000ff00, PPI_RESP_OKAY);
    cyc(2);
    chk({16'h0, pull_up, pull_dn}, 32'h0000f00f);
    pins(8'h00, 8'h00);
    rd(PPI_OFF_PIN_LVL, 32'h000000f0, PPI_RESP_OKAY);
    pins(8'hff, 8'hff);
    // Falling edge, selected and unselected pins
    wr(PPI_OFF_CTRL, 32'h0, PPI_RESP_OKAY);
    wr(PPI_OFF_EDGE_SEL, 32'h0, PPI_RESP_OKAY);
    wr(PPI_OFF_PIN_SEL, 32'h01, PPI_RESP_OKAY);
    wr(PPI_OFF_MASK, 32'h01, PPI_RESP_OKAY);
    wr(PPI_OFF_STATUS, 32'h01, PPI_RESP_OKAY);
    pins(8'hff, 8'hfd);
    rd(PPI_OFF_STATUS, 32'h0, PPI_RESP_OKAY);
    pins(8'hff, 8'hfc);
    rd(PPI_OFF_STATUS, 32'h1, PPI_RESP_OKAY);
    chk({31'h0, irq}, 32'h1);
    pins(8'hff, 8'hff);
    rd(PPI_OFF_STATUS, 32'h1, PPI_RESP_OKAY);
    wr(PPI_OFF_STATUS, 32'h01, PPI_RESP_OKAY);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    // Rising edge on an edge-select 1 pin, pulls disabled
    wr(PPI_OFF_PIN_SEL, 32'h04, PPI_RESP_OKAY);
    wr(PPI_OFF_EDGE_SEL, 32'h04, PPI_RESP_OKAY);
    pins(8'hff, 8'hfb);
    wr(PPI_OFF_STATUS, 32'h01, PPI_RESP_OKAY);
    rd(PPI_OFF_STATUS, 32'h0, PPI_RESP_OKAY);
    pins(8'hff, 8'hff);
    rd(PPI_OFF_STATUS, 32'h1, PPI_RESP_OKAY);
    // Level mode keeps the request up, mask gates the output
    wr(PPI_OFF_CTRL, 32'h01, PPI_RESP_OKAY);
    pins(8'hff, 8'hfb);
    wr(PPI_OFF_EDGE_SEL, 32'h0, PPI_RESP_OKAY);
    wr(PPI_OFF_STATUS, 32'h01, PPI_RESP_OKAY);
    rd(PPI_OFF_STATUS, 32'h1, PPI_RESP_OKAY);
    wr(PPI_OFF_MASK, 32'h0, PPI_RESP_OKAY);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    wr(PPI_OFF_MASK, 32'h01, PPI_RESP_OKAY);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    conclude();
  end
endmodule
